// ### nva_pkg.sv
`default_nettype none
package nva_pkg;

  // bus and array geometry
  localparam int APB_AW = 12;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h08;
  localparam logic [7:0] IDX_ADDR = 8'h09;
  localparam logic [7:0] IDX_CTRL = 8'h88;
  localparam logic [7:0] IDX_UNLOCK = 8'h89;
  localparam logic [7:0] IDX_IRQEN = 8'h8a;

  // nv_control_reg field positions, and the irq enable bit position
  localparam int CB_FETCH = 0;
  localparam int CB_PROG = 1;
  localparam int CB_PERMIT = 2;
  localparam int CB_ABORT = 3;
  localparam int CB_DONE = 4;
  localparam int IE_BIT = 0;

  // unlock keys and erased cell value
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // write timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_NS = 1000;
  localparam int PROG_TIME_NS = 1000;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] ERASE_CYC =
    TMR_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PROG_CYC =
    TMR_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b100
  } nva_wstate_t;

  typedef enum logic [2:0] {
    SEQ_NONE = 3'b001,
    SEQ_KEY1 = 3'b010,
    SEQ_KEY2 = 3'b100
  } nva_seq_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
    logic done;
    logic abort;
    logic permit;
    logic prog;
    logic fetch;
    logic irq_en;
    nva_seq_t seq;
    nva_wstate_t st;
    logic [TMR_W-1:0] tmr;
    logic [MEM_AW-1:0] wadr;
    logic [7:0] wdat;
    logic [31:0] prdata;
    logic [7:0] pgm_rdata;
    logic pgm_denied;
  } nva_state_t;

  localparam nva_state_t STATE_RST = '{
    data: 8'h00, addr: 8'h00, done: 1'b0, abort: 1'b0, permit: 1'b0,
    prog: 1'b0, fetch: 1'b0, irq_en: 1'b0, seq: SEQ_NONE, st: ST_IDLE,
    tmr: '0, wadr: '0, wdat: 8'h00, prdata: 32'h0000_0000,
    pgm_rdata: 8'h00, pgm_denied: 1'b0};

endpackage
`default_nettype wire

// ### nva_ctrl.sv
// Function
// - 64 bytes addressed 0h to 3Fh
// - data and address registers hold byte, location
// - each write erases cell then programs
// - internal timer sets write duration
// - CPU access kept under code protection
// - fetch_go loads data register next cycle
// - data register holds until read or write
// - fetch_go set-only, hardware clears it
// - write needs 55h, AAh, then program_go
// - program_go needs write_permit, set-only
// - write_permit software-only, clearing keeps write
// - completion clears program_go, sets done flag
// - other reset during write sets abort
// - control bits 7 to 5 read zero
// - unlock port stores nothing
// - done flag sets regardless of enables
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module nva_ctrl (
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_other_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [nva_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // external programmer read port
  input wire logic i_code_protect,
  input wire logic i_pgm_rd,
  input wire logic [nva_pkg::MEM_AW-1:0] i_pgm_addr,
  output logic [7:0] o_pgm_rdata,
  output logic o_pgm_denied,
  // status
  output logic o_write_done_irq,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [nva_pkg::APB_AW-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  nva_pkg::nva_state_t q;
  nva_pkg::nva_state_t d;
  logic [7:0] mem [nva_pkg::MEM_DEPTH];
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] rd_val;
  logic acc;
  logic wr;
  logic mapped;
  logic finish;
  logic [7:0] ctrl_rd;

  assign rd_val = mem[q.addr[nva_pkg::MEM_AW-1:0]];
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite;
  assign mapped = hit(i_paddr, nva_pkg::IDX_DATA) |
                  hit(i_paddr, nva_pkg::IDX_ADDR) |
                  hit(i_paddr, nva_pkg::IDX_CTRL) |
                  hit(i_paddr, nva_pkg::IDX_UNLOCK) |
                  hit(i_paddr, nva_pkg::IDX_IRQEN);
  assign finish = (q.st == nva_pkg::ST_PROG) && (q.tmr == '0);
  assign ctrl_rd = {3'b000, q.done, q.abort, q.permit, q.prog, q.fetch};

  assign o_pready = acc;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = q.prdata;
  assign o_pgm_rdata = q.pgm_rdata;
  assign o_pgm_denied = q.pgm_denied;
  assign o_write_done_irq = q.done & q.irq_en;
  assign o_busy = q.prog;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_wd = q.wdat;
    // read: one cycle after fetch_go the byte is in the data register
    d.fetch = 1'b0;
    if (q.fetch) begin
      d.data = rd_val;
    end
    // setup phase captures read data so prdata comes from a flop
    if (i_psel && !i_penable) begin
      d.prdata = 32'h0000_0000;
      if (hit(i_paddr, nva_pkg::IDX_DATA)) begin
        d.prdata[7:0] = q.data;
      end else if (hit(i_paddr, nva_pkg::IDX_ADDR)) begin
        d.prdata[7:0] = q.addr;
      end else if (hit(i_paddr, nva_pkg::IDX_CTRL)) begin
        d.prdata[7:0] = ctrl_rd;
      end else if (hit(i_paddr, nva_pkg::IDX_IRQEN)) begin
        d.prdata[nva_pkg::IE_BIT] = q.irq_en;
      end
    end
    if (wr) begin
      // any write breaks a pending unlock unless it is the next key
      d.seq = nva_pkg::SEQ_NONE;
      if (hit(i_paddr, nva_pkg::IDX_DATA)) begin
        d.data = i_pwdata[7:0];
      end else if (hit(i_paddr, nva_pkg::IDX_ADDR)) begin
        d.addr = i_pwdata[7:0];
      end else if (hit(i_paddr, nva_pkg::IDX_UNLOCK)) begin
        if (i_pwdata[7:0] == nva_pkg::UNLOCK_KEY1) begin
          d.seq = nva_pkg::SEQ_KEY1;
        end else if (q.seq == nva_pkg::SEQ_KEY1 &&
                     i_pwdata[7:0] == nva_pkg::UNLOCK_KEY2) begin
          d.seq = nva_pkg::SEQ_KEY2;
        end
      end else if (hit(i_paddr, nva_pkg::IDX_IRQEN)) begin
        d.irq_en = i_pwdata[nva_pkg::IE_BIT];
      end else if (hit(i_paddr, nva_pkg::IDX_CTRL)) begin
        d.permit = i_pwdata[nva_pkg::CB_PERMIT];
        d.abort = i_pwdata[nva_pkg::CB_ABORT];
        d.done = i_pwdata[nva_pkg::CB_DONE];
        if (i_pwdata[nva_pkg::CB_FETCH]) begin
          d.fetch = 1'b1;
        end
        if (i_pwdata[nva_pkg::CB_PROG] && q.permit &&
            q.seq == nva_pkg::SEQ_KEY2 && q.st == nva_pkg::ST_IDLE) begin
          // latch target so later register writes cannot disturb it
          d.prog = 1'b1;
          d.st = nva_pkg::ST_ERASE;
          d.tmr = nva_pkg::ERASE_CYC - 1'b1;
          d.wadr = q.addr[nva_pkg::MEM_AW-1:0];
          d.wdat = q.data;
        end
      end
    end
    // write engine: erase phase, then program phase, each timed
    unique case (q.st)
      nva_pkg::ST_IDLE: begin
      end
      nva_pkg::ST_ERASE: begin
        if (q.tmr == '0) begin
          mem_we = 1'b1;
          mem_wd = nva_pkg::ERASED_BYTE;
          d.st = nva_pkg::ST_PROG;
          d.tmr = nva_pkg::PROG_CYC - 1'b1;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      nva_pkg::ST_PROG: begin
        if (q.tmr == '0) begin
          mem_we = 1'b1;
          mem_wd = q.wdat;
          d.st = nva_pkg::ST_IDLE;
          d.prog = 1'b0;
          d.done = 1'b1;
          d.abort = 1'b0;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      default: begin
        d.st = nva_pkg::ST_IDLE;
        d.prog = 1'b0;
      end
    endcase
    // programmer side: refused while protected, cpu unaffected
    d.pgm_denied = i_pgm_rd & i_code_protect;
    if (i_pgm_rd && !i_code_protect) begin
      d.pgm_rdata = mem[i_pgm_addr];
    end
    // clear or watchdog reset: control cleared except abort, which is set if a write was running; data/address kept
    if (i_other_rst) begin
      d.abort = (q.st != nva_pkg::ST_IDLE);
      d.done = 1'b0;
      d.permit = 1'b0;
      d.prog = 1'b0;
      d.fetch = 1'b0;
      d.seq = nva_pkg::SEQ_NONE;
      d.st = nva_pkg::ST_IDLE;
      d.tmr = '0;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= nva_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  // array has no reset: contents are nonvolatile
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[q.wadr] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  logic [7:0] mem_at_wadr;
  assign mem_at_wadr = mem[q.wadr];

  chk_fetch_load: assert property (
    q.fetch && !i_other_rst && !(wr && hit(i_paddr, nva_pkg::IDX_DATA))
    |=> q.data == $past(rd_val))
    else $error("read byte not in data register next cycle");

  chk_fetch_selfclr: assert property (
    q.fetch |=> !q.fetch || $past(wr && i_pwdata[nva_pkg::CB_FETCH]))
    else $error("fetch_go not cleared by hardware");

  chk_data_hold: assert property (
    !q.fetch && !(wr && hit(i_paddr, nva_pkg::IDX_DATA)) |=> $stable(q.data))
    else $error("data register changed without read or write");

  chk_prog_permit: assert property (
    $rose(q.prog) |-> $past(q.permit))
    else $error("program_go set without write_permit");

  chk_prog_unlock: assert property (
    $rose(q.prog) |-> $past(q.seq == nva_pkg::SEQ_KEY2))
    else $error("write started without unlock sequence");

  chk_write_time: assert property (
    $rose(q.prog) ##1 !i_other_rst [*8] |-> q.prog)
    else $error("write ended before timer");

  chk_write_len: assert property (
    $rose(q.prog) |-> ##[1:200] !q.prog)
    else $error("write ran past timer");

  chk_done_set: assert property (
    finish && !i_other_rst |=> q.done && !q.prog && q.st == nva_pkg::ST_IDLE)
    else $error("completion did not set done flag");

  chk_erase_first: assert property (
    q.st == nva_pkg::ST_ERASE && q.tmr == '0 && !i_other_rst
    |=> mem_at_wadr == nva_pkg::ERASED_BYTE)
    else $error("cell not erased before programming");

  chk_abort_set: assert property (
    i_other_rst && q.st != nva_pkg::ST_IDLE |=> q.abort && !q.prog)
    else $error("aborted write did not set abort flag");

  chk_ctrl_upper: assert property (
    i_psel && !i_penable && hit(i_paddr, nva_pkg::IDX_CTRL)
    |=> q.prdata[31:5] == 27'h0)
    else $error("control upper bits not zero");

  chk_pgm_refuse: assert property (
    i_pgm_rd && i_code_protect |=> o_pgm_denied && $stable(o_pgm_rdata))
    else $error("programmer read not refused");

  // timer checks: together they fix the write at its full length
  chk_erase_load: assert property (
    $rose(q.prog)
    |-> q.st == nva_pkg::ST_ERASE && q.tmr == nva_pkg::ERASE_CYC - 8'h01)
    else $error("erase phase did not load its full count");

  chk_prog_load: assert property (
    q.st == nva_pkg::ST_ERASE && q.tmr == '0 && !i_other_rst
    |=> q.st == nva_pkg::ST_PROG && q.tmr == nva_pkg::PROG_CYC - 8'h01)
    else $error("program phase did not load its full count");

  chk_tmr_step: assert property (
    q.st != nva_pkg::ST_IDLE && q.tmr != '0 && !i_other_rst
    |=> q.tmr == $past(q.tmr) - 8'h01 && $stable(q.st))
    else $error("write timer did not count down by one");

  chk_prog_hold: assert property (
    q.prog && !finish && !i_other_rst
    |=> q.prog)
    else $error("write stopped before its timer ran out");

  // flags that only software, a reset or write completion may change
  chk_permit_keep: assert property (
    !(wr && hit(i_paddr, nva_pkg::IDX_CTRL)) && !i_other_rst
    |=> $stable(q.permit))
    else $error("write_permit changed without software");

  chk_done_sticky: assert property (
    q.done && !(wr && hit(i_paddr, nva_pkg::IDX_CTRL)) && !i_other_rst
    |=> q.done)
    else $error("write_done_flag cleared without software");

  chk_abort_clean: assert property (
    finish && !i_other_rst
    |=> !q.abort)
    else $error("completed write left abort flag set");

  chk_unlock_break: assert property (
    wr && !hit(i_paddr, nva_pkg::IDX_UNLOCK)
    |=> q.seq == nva_pkg::SEQ_NONE)
    else $error("unlock sequence survived another write");

  chk_other_keep: assert property (
    i_other_rst && !wr && !q.fetch
    |=> $stable(q.data) && $stable(q.addr))
    else $error("other reset changed data or address register");

  chk_other_clear: assert property (
    i_other_rst
    |=> !q.done && !q.permit && !q.prog && !q.fetch &&
        q.st == nva_pkg::ST_IDLE)
    else $error("other reset left control state set");

  chk_pgm_allow: assert property (
    i_pgm_rd && !i_code_protect
    |=> !o_pgm_denied)
    else $error("programmer read refused while unprotected");

  cov_read: cover property (q.fetch ##1 !q.fetch);
  cov_write_done: cover property (finish ##1 q.done);
  cov_abort: cover property (i_other_rst && q.prog);
  cov_bad_unlock: cover property (
    wr && hit(i_paddr, nva_pkg::IDX_CTRL) && i_pwdata[nva_pkg::CB_PROG] &&
    q.permit && q.seq != nva_pkg::SEQ_KEY2);
  cov_late_clear: cover property (
    q.prog && wr && hit(i_paddr, nva_pkg::IDX_CTRL) &&
    !i_pwdata[nva_pkg::CB_PERMIT]);

endmodule
`default_nettype wire

// ### nva_pgm_model.sv
`timescale 1ns/1ps
`default_nettype none
module nva_pgm_model (
  // clock
  input wire logic i_mclk,
  // programmer read port
  output logic o_rd,
  output logic [5:0] o_addr,
  input wire logic [7:0] i_rdata,
  input wire logic i_denied
);
  initial begin
    o_rd = 1'b0;
    o_addr = 6'h00;
  end
  // request after an edge, answer taken one cycle after it is accepted
  task automatic read_cell(input logic [5:0] a, output logic [7:0] d,
                           output logic den);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_mclk);
    d = i_rdata;
    den = i_denied;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rstn, orst, psel, pen, pwr, prot, pready, pslverr;
  logic prd, den, irq, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] padr;
  logic [7:0] prdat, a, d, la, ld, pd;
  int mismatches, tests_run, seed, k;
  nva_ctrl uut (.i_mclk(mclk), .i_rstn(rstn), .i_other_rst(orst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_code_protect(prot), .i_pgm_rd(prd),
    .i_pgm_addr(padr), .o_pgm_rdata(prdat), .o_pgm_denied(den),
    .o_write_done_irq(irq), .o_busy(busy));
  nva_pgm_model pgm (.i_mclk(mclk), .o_rd(prd), .o_addr(padr),
    .i_rdata(prdat), .i_denied(den));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic [31:0] ctl(logic dn, logic ab, logic pm);
    return {27'h0, dn, ab, pm, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] v);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= v;
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic seq(input logic [31:0] p, input logic [7:0] k1, k2);
    apb(1, nva_pkg::IDX_CTRL, p);
    apb(1, nva_pkg::IDX_UNLOCK, {24'h0, k1});
    apb(1, nva_pkg::IDX_UNLOCK, {24'h0, k2});
    apb(1, nva_pkg::IDX_CTRL, 32'h6);
  endtask
  task automatic start_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, nva_pkg::IDX_ADDR, {24'h0, a});
    apb(1, nva_pkg::IDX_DATA, {24'h0, d});
    seq(32'h4, 8'h55, 8'haa);
  endtask
  function automatic int wr_cycles(input int skip);
    return int'(nva_pkg::ERASE_CYC) + int'(nva_pkg::PROG_CYC) - skip;
  endfunction
  task automatic wait_idle(input int x);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400) mismatches++;
    chk(n, x);
  endtask
  task automatic rd_cell(input logic [7:0] a);
    apb(1, nva_pkg::IDX_ADDR, {24'h0, a});
    apb(1, nva_pkg::IDX_CTRL, 32'h1);
    apb(0, nva_pkg::IDX_DATA, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
  initial begin
    seed = 29;
    {rstn, orst, psel, pen, pwr, prot} = 6'b000000;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apb(0, nva_pkg::IDX_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1, nva_pkg::IDX_CTRL, 32'hfe);
    apb(0, nva_pkg::IDX_CTRL, 32'h0);
    chk(r, ctl(1, 1, 1));
    $display("reset and control bits done");
    for (k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'h00 : (k == 1) ? 8'h3f : 8'($random(seed)) & 8'h3f;
      d = 8'($random(seed));
      start_wr(a, d);
      chk(busy, 1);
      if (k[0]) apb(1, nva_pkg::IDX_CTRL, 32'h0);
      wait_idle(wr_cycles(k[0] ? 3 : 0));
      apb(0, nva_pkg::IDX_CTRL, 32'h0);
      chk(r, ctl(1, 0, !k[0]));
      apb(1, nva_pkg::IDX_DATA, {24'h0, ~d});
      rd_cell(a);
      chk(r, {24'h0, d});
      apb(0, nva_pkg::IDX_DATA, 32'h0);
      chk(r, {24'h0, d});
    end
    la = a;
    ld = d;
    $display("write and read back done");
    start_wr(la, ld);
    wait_idle(wr_cycles(0));
    chk(irq, 0);
    apb(0, nva_pkg::IDX_CTRL, 32'h0);
    chk(r, ctl(1, 0, 1));
    apb(1, nva_pkg::IDX_IRQEN, 32'h1);
    chk(irq, 1);
    apb(0, nva_pkg::IDX_IRQEN, 32'h0);
    chk(r, 32'h1);
    apb(1, nva_pkg::IDX_CTRL, 32'h0);
    chk(irq, 0);
    $display("irq done");
    seq(32'h4, 8'haa, 8'h55);
    chk(busy, 0);
    seq(32'h4, 8'h55, 8'h55);
    chk(busy, 0);
    seq(32'h0, 8'h55, 8'haa);
    chk(busy, 0);
    $display("refused writes done");
    start_wr(la ^ 8'h01, 8'hc3);
    repeat (10) @(posedge mclk);
    orst <= 1'b1;
    @(posedge mclk);
    orst <= 1'b0;
    @(posedge mclk);
    apb(0, nva_pkg::IDX_CTRL, 32'h0);
    chk(r, ctl(0, 1, 0));
    apb(0, nva_pkg::IDX_DATA, 32'h0);
    chk(r, 32'hc3);
    $display("abort done");
    apb(1, 8'h40, 32'hff);
    chk(e, 1);
    apb(0, nva_pkg::IDX_UNLOCK, 32'h0);
    chk(r, 32'h0);
    prot <= 1'b1;
    pgm.read_cell(la[5:0], pd, e);
    chk(e, 1);
    rd_cell(la);
    chk(r, {24'h0, ld});
    prot <= 1'b0;
    pgm.read_cell(la[5:0], pd, e);
    chk(pd, ld);
    $display("protection done");
    wrap_up();
  end
endmodule
`default_nettype wire
